// ### ticc_pkg.sv
// package for the timer input capture channel configuration block
// assumes a single 40 MHz clock and an APB register port
package ticc_pkg;
  localparam int          CLK_HZ            = 40_000_000;
  localparam logic [11:0] OFS_CHAN_CFG      = 12'h018;
  localparam logic [11:0] OFS_CHAN_EN       = 12'h020;
  localparam logic [31:0] RST_CHAN_CFG      = 32'h0000_0000;
  localparam int          POS_CH0_ROUTE     = 0;
  localparam int          POS_CH0_DIV       = 2;
  localparam int          POS_CH0_FILT      = 4;
  localparam int          POS_CH1_ROUTE     = 8;
  localparam int          POS_CH1_DIV       = 10;
  localparam int          POS_CH1_FILT      = 12;
  localparam int          POS_CH0_EN        = 0;
  localparam int          POS_CH1_EN        = 4;
  localparam int          CFG_USED_BITS     = 16;
  localparam logic [1:0]  ROUTE_OUTPUT      = 2'b00;
  localparam logic [1:0]  ROUTE_OWN         = 2'b01;
  localparam logic [1:0]  ROUTE_NEIGHBOUR   = 2'b10;
  localparam logic [1:0]  ROUTE_TRIGGER     = 2'b11;
  // dead-time sampling clock divider, ratio to the kernel clock
  localparam logic [7:0]  DTS_DIV_DEFAULT   = 8'h01;
endpackage : ticc_pkg

// ### ticc_filter.sv
// digital glitch filter plus edge prescaler for one capture channel
// assumes input already synchronised, dts_tick is a one-cycle enable
`timescale 1ns/1ps
module ticc_filter
  import ticc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       raw_in,
  input  wire logic       dts_tick,
  input  wire logic [3:0] filter_sel,
  input  wire logic [1:0] edge_divider,
  input  wire logic       active_bit,
  input  wire logic       edge_in,
  output logic            filt_out,
  output logic            capture_pulse
);
  logic [4:0] div_ff;
  logic [4:0] dts_cnt_ff;
  logic [3:0] run_ff;
  logic       prev_ff;
  logic       filt_ff;
  logic [2:0] psc_ff;
  logic [3:0] need;
  logic [4:0] ratio;
  logic       samp;
  logic       cap_ff;

  always_comb
  begin
    ratio = 5'd0;
    need  = 4'd1;
    case (filter_sel)
      4'h0: need = 4'd1;
      4'h1: need = 4'd2;
      4'h2: need = 4'd4;
      4'h3: need = 4'd8;
      4'h4: begin ratio = 5'd1;  need = 4'd6; end
      4'h5: begin ratio = 5'd1;  need = 4'd8; end
      4'h6: begin ratio = 5'd3;  need = 4'd6; end
      4'h7: begin ratio = 5'd3;  need = 4'd8; end
      4'h8: begin ratio = 5'd7;  need = 4'd6; end
      4'h9: begin ratio = 5'd7;  need = 4'd8; end
      4'ha: begin ratio = 5'd15; need = 4'd5; end
      4'hb: begin ratio = 5'd15; need = 4'd6; end
      4'hc: begin ratio = 5'd15; need = 4'd8; end
      4'hd: begin ratio = 5'd31; need = 4'd5; end
      4'he: begin ratio = 5'd31; need = 4'd6; end
      default: begin ratio = 5'd31; need = 4'd8; end
    endcase
    samp = (filter_sel < 4'h4) ? 1'b1 : (dts_tick && (dts_cnt_ff == ratio));
  end

  // divide the sampling clock by 2..32
  always_ff @(posedge clock)
  begin
    if (!resetn)
      dts_cnt_ff <= 5'd0;
    else if (dts_tick)
      dts_cnt_ff <= (dts_cnt_ff >= ratio) ? 5'd0 : dts_cnt_ff + 5'd1;
  end

  // count equal consecutive samples; restart on a change
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      run_ff  <= 4'd0;
      prev_ff <= 1'b0;
      filt_ff <= 1'b0;
    end
    else if (filter_sel == 4'h0)
    begin
      filt_ff <= raw_in;
      prev_ff <= raw_in;
      run_ff  <= 4'd0;
    end
    else if (samp)
    begin
      prev_ff <= raw_in;
      if (raw_in != prev_ff)
        run_ff <= 4'd1;
      else if (run_ff < need)
        run_ff <= run_ff + 4'd1;
      if ((raw_in == prev_ff) && (run_ff + 4'd1 >= need))
        filt_ff <= raw_in;
    end
  end

  // edge prescaler, count held at zero while the channel is off
  always_ff @(posedge clock)
  begin
    if (!resetn || !active_bit)
    begin
      psc_ff <= 3'd0;
      cap_ff <= 1'b0;
    end
    else
    begin
      cap_ff <= 1'b0;
      if (edge_in)
      begin
        case (edge_divider)
          2'b00: begin cap_ff <= 1'b1; psc_ff <= 3'd0; end
          2'b01: begin cap_ff <= psc_ff[0]; psc_ff <= {2'b00, ~psc_ff[0]}; end
          2'b10: begin cap_ff <= (psc_ff[1:0] == 2'd3); psc_ff <= {1'b0, psc_ff[1:0] + 2'd1}; end
          default: begin cap_ff <= (psc_ff == 3'd7); psc_ff <= psc_ff + 3'd1; end
        endcase
      end
    end
  end

  assign filt_out      = filt_ff;
  assign capture_pulse = cap_ff;

  AST_PSC_OFF: assert property (@(posedge clock) disable iff (!resetn)
    !active_bit |=> (psc_ff == 3'd0)) else $error("prescaler not cleared");
  AST_BYPASS: assert property (@(posedge clock) disable iff (!resetn)
    (filter_sel == 4'h0) |=> (filt_ff == $past(raw_in))) else $error("bypass broken");
  AST_DIV1: assert property (@(posedge clock) disable iff (!resetn)
    (active_bit && edge_divider == 2'b00 && edge_in) |=> cap_ff) else $error("missed capture");
  AST_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    (filter_sel != 4'h0 && !samp) |=> $stable(filt_ff)) else $error("filter moved unsampled");
endmodule : ticc_filter

// ### ticc_top.sv
// two-channel capture input configuration with an APB register port
// assumes channel inputs are asynchronous pins; one 40 MHz clock
//
// Function
// - apart from code zero, the filter samples continuously and accepts a level only after enough equal samples.
// - code zero bypasses; codes one to three sample at the kernel clock needing 2, 4, 8 samples.
// - codes four to fifteen sample at divided dead-time rates needing 6/8 or 5/6/8 samples.
// - the prescaler captures on every 1st, 2nd, 4th or 8th valid edge.
// - the prescaler count is cleared while the channel enable is zero.
// - channel 0 fields sit at 7:4 and 3:2, channel 1 at 15:12 and 11:10.
// - route fields at 1:0 and 9:8 mean the same in capture and compare use.
// - route 00 is output, 01 own input, 10 neighbour input, 11 internal trigger.
// - a route field changes only while its channel enable is cleared.
`timescale 1ns/1ps
module ticc_top
  import ticc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        channel0_raw_input,
  input  wire logic        channel1_raw_input,
  input  wire logic        internal_trigger_select,
  input  wire logic [7:0]  dts_ratio,
  output logic             ch0_capture,
  output logic             ch1_capture,
  output logic             ch0_is_output,
  output logic             ch1_is_output
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] cfg_ff;
  logic [1:0]  en_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [1:0]  s0_ff, s1_ff;
  logic [1:0]  is_ff;
  logic [7:0]  dts_cnt_ff;
  logic        dts_tick;
  logic        f0, f1, p0_ff, p1_ff, t_prev_ff;
  logic        e0, e1, c0, c1;
  logic        cap0_ff, cap1_ff, out0_ff, out1_ff;
  logic        wr, rd;

  // writes commit on the edge that completes the transfer, with pready high
  assign wr = psel && penable && pwrite && pready_ff;
  assign rd = psel && penable && !pwrite && !pready_ff;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, unmapped address answers pslverr
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && (paddr != OFS_CHAN_CFG) && (paddr != OFS_CHAN_EN);
      prdata_ff  <= 32'h0000_0000;
      if (rd && paddr == OFS_CHAN_CFG)
        prdata_ff <= {16'h0000, cfg_ff}; // reserved reads zero
      else if (rd && paddr == OFS_CHAN_EN)
        prdata_ff <= {27'h000_0000, en_ff[1], 3'b000, en_ff[0]};
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      cfg_ff <= RST_CHAN_CFG[15:0];
    else if (wr && paddr == OFS_CHAN_CFG)
    begin
      cfg_ff[7:2]   <= pwdata[7:2];
      cfg_ff[15:10] <= pwdata[15:10];
      if (!en_ff[0])
        cfg_ff[1:0] <= pwdata[1:0];
      if (!en_ff[1])
        cfg_ff[9:8] <= pwdata[9:8];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      en_ff <= 2'b00;
    else if (wr && paddr == OFS_CHAN_EN)
      en_ff <= {pwdata[POS_CH1_EN], pwdata[POS_CH0_EN]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and the dead-time sample enable
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      s0_ff <= 2'b00;
      s1_ff <= 2'b00;
      is_ff <= 2'b00;
      dts_cnt_ff <= 8'h00;
    end
    else
    begin
      s0_ff <= {s0_ff[0], channel0_raw_input};
      s1_ff <= {s1_ff[0], channel1_raw_input};
      is_ff <= {is_ff[0], internal_trigger_select};
      dts_cnt_ff <= (dts_cnt_ff + 8'h01 >= dts_ratio) ? 8'h00 : dts_cnt_ff + 8'h01;
    end
  end
  assign dts_tick = (dts_cnt_ff == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // rising edges of filtered inputs and trigger, then route selection
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      p0_ff <= 1'b0;
      p1_ff <= 1'b0;
      t_prev_ff <= 1'b0;
    end
    else
    begin
      p0_ff <= f0;
      p1_ff <= f1;
      t_prev_ff <= is_ff[1];
    end
  end

  function automatic logic route(input logic [1:0] sel, input logic own, input logic nb, input logic trg);
    case (sel)
      ROUTE_OWN:       route = own;
      ROUTE_NEIGHBOUR: route = nb;
      ROUTE_TRIGGER:   route = trg;
      default:         route = 1'b0;
    endcase
  endfunction : route

  assign e0 = route(cfg_ff[POS_CH0_ROUTE +: 2], f0 && !p0_ff, f1 && !p1_ff, is_ff[1] && !t_prev_ff);
  assign e1 = route(cfg_ff[POS_CH1_ROUTE +: 2], f1 && !p1_ff, f0 && !p0_ff, is_ff[1] && !t_prev_ff);

  ticc_filter u_ch0 (
    .clock        (clock),
    .resetn       (resetn),
    .raw_in       (s0_ff[1]),
    .dts_tick     (dts_tick),
    .filter_sel   (cfg_ff[POS_CH0_FILT +: 4]),
    .edge_divider (cfg_ff[POS_CH0_DIV +: 2]),
    .active_bit   (en_ff[0]),
    .edge_in      (e0),
    .filt_out     (f0),
    .capture_pulse(c0)
  );

  ticc_filter u_ch1 (
    .clock        (clock),
    .resetn       (resetn),
    .raw_in       (s1_ff[1]),
    .dts_tick     (dts_tick),
    .filter_sel   (cfg_ff[POS_CH1_FILT +: 4]),
    .edge_divider (cfg_ff[POS_CH1_DIV +: 2]),
    .active_bit   (en_ff[1]),
    .edge_in      (e1),
    .filt_out     (f1),
    .capture_pulse(c1)
  );

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cap0_ff <= 1'b0;
      cap1_ff <= 1'b0;
      out0_ff <= 1'b1;
      out1_ff <= 1'b1;
    end
    else
    begin
      cap0_ff <= c0 && (cfg_ff[1:0] != ROUTE_OUTPUT);
      cap1_ff <= c1 && (cfg_ff[9:8] != ROUTE_OUTPUT);
      out0_ff <= (cfg_ff[1:0] == ROUTE_OUTPUT);
      out1_ff <= (cfg_ff[9:8] == ROUTE_OUTPUT);
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign ch0_capture   = cap0_ff;
  assign ch1_capture   = cap1_ff;
  assign ch0_is_output = out0_ff;
  assign ch1_is_output = out1_ff;

  AST_ROUTE_LOCK: assert property (@(posedge clock) disable iff (!resetn)
    en_ff[0] |=> (cfg_ff[1:0] == $past(cfg_ff[1:0]))) else $error("route changed while active");
  AST_ROUTE_LOCK1: assert property (@(posedge clock) disable iff (!resetn)
    en_ff[1] |=> (cfg_ff[9:8] == $past(cfg_ff[9:8]))) else $error("ch1 route changed while active");
  AST_FIELDS: assert property (@(posedge clock) disable iff (!resetn)
    (wr && paddr == OFS_CHAN_CFG) |=> (cfg_ff[15:10] == $past(pwdata[15:10]))) else $error("field lost");
  AST_OUT_NOCAP: assert property (@(posedge clock) disable iff (!resetn)
    ch0_is_output |-> !ch0_capture) else $error("capture on output");
  AST_PREADY: assert property (@(posedge clock) disable iff (!resetn)
    (psel && penable && !pready_ff) |=> pready_ff) else $error("no ready");
endmodule : ticc_top

// ### ticc_top_tb_top.sv
// self-checking bench for the two-channel capture input configuration block
// assumes one 40 MHz clock, an apb slave that answers with pready, dts_ratio mostly one
`timescale 1ns/1ps
module ticc_top_tb_top;
  import ticc_pkg::*;
  logic        clock     = 1'b0;
  logic        resetn    = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = '0;
  logic [31:0] pwdata    = '0;
  logic        in0       = 1'b0;
  logic        in1       = 1'b0;
  logic        trig      = 1'b0;
  logic [7:0]  dts_ratio = 8'h01;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cap0;
  logic        cap1;
  logic        out0;
  logic        out1;
  logic [31:0] m_cfg     = RST_CHAN_CFG;
  logic [31:0] m_en      = '0;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail    = 0;
  int          tests_run = 0;
  int          cnt0      = 0;
  int          cnt1      = 0;
  int          n;
  int          c;
  // high time per filter code 1..15: too short to qualify, then long enough to qualify
  int          wsh[15]   = '{1, 3, 5, 8, 10, 16, 24, 32, 48, 50, 64, 96, 96, 128, 150};
  int          wlg[15]   = '{6, 8, 14, 20, 24, 30, 40, 60, 80, 120, 120, 150, 180, 220, 400};

  ticc_top i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel0_raw_input(in0), .channel1_raw_input(in1), .internal_trigger_select(trig),
    .dts_ratio(dts_ratio), .ch0_capture(cap0), .ch1_capture(cap1), .ch0_is_output(out0),
    .ch1_is_output(out1));

  always #12.5 clock = ~clock;

  // capture pulses stand one cycle, so every edge is looked at
  always @(posedge clock)
  begin
    if (cap0 === 1'b1) cnt0++;
    if (cap1 === 1'b1) cnt1++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == OFS_CHAN_CFG)
    begin
      if (m_en[POS_CH0_EN]) d[1:0] = m_cfg[1:0];
      if (m_en[POS_CH1_EN]) d[9:8] = m_cfg[9:8];
      m_cfg = {16'h0000, d[15:0]};
    end
    else if (a == OFS_CHAN_EN) m_en = d;
  endtask : wr

  task rdcfg;
    apb(1'b0, OFS_CHAN_CFG, '0);
    chk("cfg", rdat, m_cfg);
    chk("cfg_pslverr", {31'h0, rerr}, 32'h0);
    chk("ch0_is_output", {31'h0, out0}, {31'h0, m_cfg[1:0] == 2'b00});
    chk("ch1_is_output", {31'h0, out1}, {31'h0, m_cfg[9:8] == 2'b00});
  endtask : rdcfg

  task setcfg(input logic [31:0] d);
    wr(OFS_CHAN_EN, 32'h0000_0000);
    wr(OFS_CHAN_CFG, d);
    wr(OFS_CHAN_EN, 32'h0000_0011);
    rdcfg();
  endtask : setcfg

  task drive(input int src, input logic v);
    if (src == 0) in0 <= v;
    else if (src == 1) in1 <= v;
    else trig <= v;
  endtask : drive

  // low gap outlasts the high time so the low level always requalifies
  task pulse(input int src, input int k, input int w);
    repeat (k)
    begin
      @(posedge clock);
      drive(src, 1'b1);
      repeat (w) @(posedge clock);
      drive(src, 1'b0);
      repeat (w + 30) @(posedge clock);
    end
    repeat (30) @(posedge clock);
  endtask : pulse

  task run(input int ch, input logic [1:0] rt, input logic [1:0] dv, input logic [3:0] ft,
           input int src, input int k, input int w, input int exp);
    setcfg(32'({ft, dv, rt}) << (8 * ch));
    c = ch ? cnt1 : cnt0;
    pulse(src, k, w);
    chk("captures", (ch ? cnt1 : cnt0) - c, exp);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(40000 * 25);
    n_fail++;
    results();
  end

  initial
  begin
    void'($urandom(59));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rdcfg();
    apb(1'b0, OFS_CHAN_EN, '0);
    chk("enable", rdat, 32'h0000_0000);
    apb(1'b1, 12'h100, 32'h0000_1234);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    rdcfg();
    wr(OFS_CHAN_EN, 32'h0000_0011);
    apb(1'b0, OFS_CHAN_EN, '0);
    chk("enable_on", rdat, 32'h0000_0011);
    wr(OFS_CHAN_CFG, 32'h0000_A5A5);
    rdcfg();
    setcfg({16'h0000, 16'($urandom)});
    for (int d = 0; d < 4; d++)
    begin
      n = 4 + $urandom % 13;
      run(0, 2'b01, d[1:0], 4'h0, 0, n, 4, n >> d);
    end
    for (int i = 0; i < 15; i++)
    begin
      run(0, 2'b01, 2'b00, 4'(i + 1), 0, 2, wsh[i], 0);
      run(0, 2'b01, 2'b00, 4'(i + 1), 0, 2, wlg[i], 2);
    end
    run(1, 2'b01, 2'b01, 4'h3, 1, 6, 14, 3);
    run(1, 2'b01, 2'b00, 4'h3, 1, 3, 5, 0);
    run(0, 2'b10, 2'b00, 4'h0, 1, 5, 4, 5);
    run(1, 2'b10, 2'b00, 4'h0, 0, 5, 4, 5);
    run(0, 2'b11, 2'b00, 4'h0, 2, 5, 4, 5);
    run(0, 2'b00, 2'b00, 4'h0, 0, 3, 4, 0);
    // a slower sampling clock stretches the divided sample period to four cycles
    dts_ratio <= 8'h02;
    run(0, 2'b01, 2'b00, 4'h4, 0, 2, 16, 0);
    run(0, 2'b01, 2'b00, 4'h4, 0, 2, 30, 2);
    dts_ratio <= 8'h01;
    run(0, 2'b01, 2'b10, 4'h0, 0, 3, 4, 0);
    wr(OFS_CHAN_EN, 32'h0000_0000);
    wr(OFS_CHAN_EN, 32'h0000_0011);
    c = cnt0;
    pulse(0, 1, 4);
    chk("cleared", cnt0 - c, 0);
    pulse(0, 3, 4);
    chk("cleared", cnt0 - c, 1);
    results();
  end
endmodule : ticc_top_tb_top
